/* File: ccd_pkg.sv */
// Purpose: shared types of the channel divider
// Assumes: nothing
// Notes: stage sequencer states
package ccd_pkg;
  typedef enum logic [1:0] {
    CCD_ST_IDLE,
    CCD_ST_DELAY,
    CCD_ST_RUN
  } ccd_stage_e;
endpackage : ccd_pkg

/* File: ccd_regs.svh */
// Purpose: register offsets, field positions and reset values of the channel divider
// Assumes: 9-bit byte address, 8-bit registers
// Notes: included by the divider top and by its bench
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define CCD_ADDR_PHASE 9'h19f
`define CCD_ADDR_LOHI 9'h1a0
`define CCD_ADDR_CTRL 9'h1a1
`define CCD_ADDR_DCC 9'h1a2
`define CCD_ADDR_STAT 9'h1a3

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define CCD_CTL_BYP2 5
`define CCD_CTL_BYP1 4
`define CCD_CTL_NOSYNC 3
`define CCD_CTL_FORCE 2
`define CCD_CTL_START2 1
`define CCD_CTL_START1 0
`define CCD_CTL_MASK 8'h3f
`define CCD_DCC_OFF 0
`define CCD_DCC_MASK 8'h01

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define CCD_STAT_OUT 0
`define CCD_STAT_S1_LVL 1
`define CCD_STAT_S1_BUSY 2
`define CCD_STAT_S2_BUSY 3
`define CCD_STAT_SYNC 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CCD_RST_PHASE 8'h00
`define CCD_RST_LOHI 8'h00
`define CCD_RST_CTRL 8'h00
`define CCD_RST_DCC 8'h00

`endif

/* File: ccd_stage.sv */
// Purpose: one programmable high/low divider stage driven by input-cycle ticks
// Assumes: in_tick_i marks one input clock cycle; align_i and hold_i never both high
// Notes: bypass parks the counter and passes the input level and tick through
`timescale 1ns/100ps

module ccd_stage #(
  parameter int CW = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // input clock of the stage
  input wire logic in_tick_i,
  input wire logic in_lvl_i,
  // configuration
  input wire logic bypass_i,
  input wire logic dcc_en_i,
  input wire logic start_high_i,
  input wire logic [CW-1:0] high_cnt_i,
  input wire logic [CW-1:0] low_cnt_i,
  input wire logic [CW-1:0] phase_i,
  // alignment
  input wire logic align_i,
  input wire logic hold_i,
  // divided output
  output logic out_lvl_o,
  output logic out_tick_o,
  output logic busy_o
);
  import ccd_pkg::*;

  ccd_stage_e st_q, st_d;
  logic [CW:0] cnt_q, cnt_d;
  logic lvl_q, lvl_d;
  logic tick_q, tick_d;
  logic [CW+1:0] tot, hi_len, lo_len;

  // length minus one of the phase that has level lvl
  function automatic logic [CW:0] len_m1(input logic lvl, input logic [CW+1:0] hi, input logic [CW+1:0] lo);
    logic [CW+1:0] v;
    v = lvl ? hi - (CW+2)'(1) : lo - (CW+2)'(1);
    return v[CW:0];
  endfunction : len_m1

  // ----------------------------------------------------------------
  // phase lengths
  // ----------------------------------------------------------------
  always_comb begin
    tot = (CW+2)'(high_cnt_i) + (CW+2)'(low_cnt_i) + (CW+2)'(2);
    if (dcc_en_i) begin
      // split the period evenly, odd spare cycle goes to the high phase
      hi_len = (tot + (CW+2)'(1)) >> 1;
      lo_len = tot >> 1;
    end else begin
      hi_len = (CW+2)'(high_cnt_i) + (CW+2)'(1);
      lo_len = (CW+2)'(low_cnt_i) + (CW+2)'(1);
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    lvl_d = lvl_q;
    tick_d = 1'b0;
    case (st_q)
      CCD_ST_IDLE: begin
        // a parked stage that is no longer held or bypassed restarts low, else it would stay stuck
        st_d = CCD_ST_RUN;
        cnt_d = len_m1(1'b0, hi_len, lo_len);
        lvl_d = 1'b0;
      end
      CCD_ST_DELAY: begin
        if (in_tick_i) begin
          if (cnt_q == '0) begin
            st_d = CCD_ST_RUN;
            cnt_d = len_m1(lvl_q, hi_len, lo_len);
          end else begin
            cnt_d = cnt_q - (CW+1)'(1);
          end
        end
      end
      CCD_ST_RUN: begin
        if (in_tick_i) begin
          if (cnt_q == '0) begin
            lvl_d = ~lvl_q;
            tick_d = ~lvl_q;
            cnt_d = len_m1(~lvl_q, hi_len, lo_len);
          end else begin
            cnt_d = cnt_q - (CW+1)'(1);
          end
        end
      end
      default: begin
        st_d = CCD_ST_IDLE;
      end
    endcase
    if (align_i) begin
      lvl_d = start_high_i;
      tick_d = start_high_i;
      if (phase_i == '0) begin
        st_d = CCD_ST_RUN;
        cnt_d = len_m1(start_high_i, hi_len, lo_len);
      end else begin
        st_d = CCD_ST_DELAY;
        cnt_d = (CW+1)'(phase_i) - (CW+1)'(1);
      end
    end
    // bypass parks the counter as a stand-in for powering it down
    if (hold_i || bypass_i) begin
      st_d = CCD_ST_IDLE;
      lvl_d = 1'b0;
      tick_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q <= CCD_ST_RUN;
      cnt_q <= '0;
      lvl_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
      tick_q <= tick_d;
    end
  end

  assign out_lvl_o = bypass_i ? in_lvl_i : lvl_q;
  assign out_tick_o = bypass_i ? in_tick_i : tick_q;
  assign busy_o = (st_q != CCD_ST_RUN);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_high_len: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(lvl_q) && $past(st_q) == CCD_ST_RUN && !$past(align_i) && !dcc_en_i && $stable(dcc_en_i) && $stable(high_cnt_i)
    |-> cnt_q == (CW+1)'(high_cnt_i)) else $error("high phase length wrong");
  chk_low_len: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $fell(lvl_q) && $past(st_q) == CCD_ST_RUN && !$past(align_i) && !dcc_en_i && !$past(hold_i || bypass_i)
    && $stable(dcc_en_i) && $stable(low_cnt_i) |-> cnt_q == (CW+1)'(low_cnt_i)) else $error("low phase length wrong");
  chk_start_lvl: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    align_i && !hold_i && !bypass_i |=> lvl_q == $past(start_high_i)) else $error("start level wrong");
  chk_phase_delay: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    align_i && !hold_i && !bypass_i && phase_i != '0 |=> st_q == CCD_ST_DELAY && cnt_q == (CW+1)'($past(phase_i)) - (CW+1)'(1))
    else $error("phase offset not loaded");
  chk_bypass_park: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    bypass_i ##1 bypass_i |-> st_q == CCD_ST_IDLE && out_tick_o == in_tick_i) else $error("bypass not parked");
endmodule : ccd_stage

/* File: ccd_top.sv */
// Purpose: two-stage programmable clock divider of output channel three
// Assumes: input clock cycles of the divider are clk_sys_i cycles; align_req_i is asynchronous
// Notes: outputs are levels sampled on clk_sys_i; a bypassed first stage is shown as a half-rate toggle
//
// Notes on behaviour
// - stage two low time is nibble plus one
// - stage two high time is nibble plus one
// - stage two bypass passes its input through
// - stage one bypass passes its input through
// - ignore-alignment bit blocks chip alignment requests
// - forced high needs ignore-alignment set too
// - stage two starts at its start level
// - stage one starts at its start level
// - duty correction on unless disable bit set
// - four-bit stage one phase offset, low nibble
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`include "ccd_regs.svh"

module ccd_top #(
  parameter int CW = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // register port
  input wire logic [8:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  // chip-level alignment
  input wire logic align_req_i,
  // divided channel output
  output logic ch_out_o,
  output logic ch_tick_o
);
  import ccd_pkg::*;

  logic [7:0] lohi_q, lohi_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] dcc_q, dcc_d;
  logic [7:0] phase_q, phase_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic sync_meta_q, sync_q, sync_prev_q;
  logic half_q, half_d;
  logic out_q, out_d;
  logic s_align, s_hold;
  logic s1_lvl, s1_tick, s1_busy;
  logic s2_lvl, s2_tick, s2_busy;
  logic [7:0] stat;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  function automatic logic [7:0] reg_read(input logic [8:0] a, input logic [7:0] lohi, input logic [7:0] ctrl,
                                          input logic [7:0] dcc, input logic [7:0] ph, input logic [7:0] st);
    case (a)
      `CCD_ADDR_PHASE: return ph;
      `CCD_ADDR_LOHI: return lohi;
      `CCD_ADDR_CTRL: return ctrl;
      `CCD_ADDR_DCC: return dcc;
      `CCD_ADDR_STAT: return st;
      default: return 8'h00;
    endcase
  endfunction : reg_read

  always_comb begin
    stat = 8'h00;
    stat[`CCD_STAT_OUT] = out_q;
    stat[`CCD_STAT_S1_LVL] = s1_lvl;
    stat[`CCD_STAT_S1_BUSY] = s1_busy;
    stat[`CCD_STAT_S2_BUSY] = s2_busy;
    stat[`CCD_STAT_SYNC] = sync_q;
  end

  always_comb begin
    lohi_d = lohi_q;
    ctrl_d = ctrl_q;
    dcc_d = dcc_q;
    phase_d = phase_q;
    if (wr_i) begin
      case (addr_i)
        `CCD_ADDR_PHASE: phase_d = wr_data_i;
        `CCD_ADDR_LOHI: lohi_d = wr_data_i;
        `CCD_ADDR_CTRL: ctrl_d = wr_data_i & `CCD_CTL_MASK;
        `CCD_ADDR_DCC: dcc_d = wr_data_i & `CCD_DCC_MASK;
        default: ;
      endcase
    end
    // data stands only in the cycle after the read strobe
    rd_data_d = rd_i ? reg_read(addr_i, lohi_q, ctrl_q, dcc_q, phase_q, stat) : 8'h00;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lohi_q <= `CCD_RST_LOHI;
      ctrl_q <= `CCD_RST_CTRL;
      dcc_q <= `CCD_RST_DCC;
      phase_q <= `CCD_RST_PHASE;
      rd_data_q <= 8'h00;
    end else begin
      lohi_q <= lohi_d;
      ctrl_q <= ctrl_d;
      dcc_q <= dcc_d;
      phase_q <= phase_d;
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data_o = rd_data_q;

  // ----------------------------------------------------------------
  // alignment request
  // ----------------------------------------------------------------
  // two flops against metastability; the release edge restarts the dividers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync_meta_q <= 1'b0;
      sync_q <= 1'b0;
      sync_prev_q <= 1'b0;
    end else begin
      sync_meta_q <= align_req_i;
      sync_q <= sync_meta_q;
      sync_prev_q <= sync_q;
    end
  end

  assign s_hold = sync_q && !ctrl_q[`CCD_CTL_NOSYNC];
  assign s_align = sync_prev_q && !sync_q && !ctrl_q[`CCD_CTL_NOSYNC];

  // ----------------------------------------------------------------
  // divider stages
  // ----------------------------------------------------------------
  // stand-in for the raw input clock when stage one is bypassed
  always_comb begin
    half_d = ~half_q;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      half_q <= 1'b0;
    end else begin
      half_q <= half_d;
    end
  end

  ccd_stage #(
    .CW(CW)
  ) u_stage1 (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_tick_i(1'b1),
    .in_lvl_i(half_q),
    .bypass_i(ctrl_q[`CCD_CTL_BYP1]),
    .dcc_en_i(1'b0),
    .start_high_i(ctrl_q[`CCD_CTL_START1]),
    .high_cnt_i(CW'(4'h0)),
    .low_cnt_i(CW'(4'h0)),
    .phase_i(phase_q[CW-1:0]),
    .align_i(s_align),
    .hold_i(s_hold),
    .out_lvl_o(s1_lvl),
    .out_tick_o(s1_tick),
    .busy_o(s1_busy)
  );

  ccd_stage #(
    .CW(CW)
  ) u_stage2 (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .in_tick_i(s1_tick),
    .in_lvl_i(s1_lvl),
    .bypass_i(ctrl_q[`CCD_CTL_BYP2]),
    .dcc_en_i(!dcc_q[`CCD_DCC_OFF]),
    .start_high_i(ctrl_q[`CCD_CTL_START2]),
    .high_cnt_i(lohi_q[CW-1:0]),
    .low_cnt_i(lohi_q[7:4]),
    .phase_i(phase_q[7:4]),
    .align_i(s_align),
    .hold_i(s_hold),
    .out_lvl_o(s2_lvl),
    .out_tick_o(s2_tick),
    .busy_o(s2_busy)
  );

  // ----------------------------------------------------------------
  // channel output
  // ----------------------------------------------------------------
  // forced high only counts with alignment ignored; otherwise held stages give the low level
  always_comb begin
    out_d = (ctrl_q[`CCD_CTL_NOSYNC] && ctrl_q[`CCD_CTL_FORCE]) ? 1'b1 : s2_lvl;
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  assign ch_out_o = out_q;
  assign ch_tick_o = s2_tick;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_nosync_ignore: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ctrl_q[`CCD_CTL_NOSYNC] && !ctrl_q[`CCD_CTL_BYP1] && !s1_busy && $stable(ctrl_q) |=> !s1_busy)
    else $error("alignment request not ignored");
  chk_force_high: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ctrl_q[`CCD_CTL_NOSYNC] && ctrl_q[`CCD_CTL_FORCE] |=> ch_out_o) else $error("forced high missing");
  chk_force_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (!ctrl_q[`CCD_CTL_NOSYNC] && !ctrl_q[`CCD_CTL_BYP1] && !ctrl_q[`CCD_CTL_BYP2] && sync_q)[*2] |=> !ch_out_o)
    else $error("output not low during alignment");
  chk_phase_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    rd_i && addr_i == `CCD_ADDR_PHASE |=> rd_data_o == $past(phase_q)) else $error("phase readback wrong");
  chk_cascade: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $rose(s2_lvl) && !ctrl_q[`CCD_CTL_BYP2] && !$past(s_align) |-> $past(s1_tick)) else $error("stage two stepped alone");
endmodule : ccd_top

/* File: ccd_top_tb.sv */
// Purpose: self-checking bench of the channel three divider top
// Assumes: divider input cycles are clk_sys_i cycles; outputs sampled 1 ns after the rising edge
// Notes: periods are measured on ch_out_o over one whole high and low phase
`timescale 1ns/100ps
`include "ccd_regs.svh"

module ccd_top_tb;
  import ccd_pkg::*;

  // ----------------------------------------------------------------
  // clock, reset and stimulus
  // ----------------------------------------------------------------
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [8:0] addr_i = 9'h000;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rd_data_o;
  logic align_req_i = 1'b0;
  logic ch_out_o;
  logic ch_tick_o;
  int err_count = 0;
  int cmp_count = 0;
  int tick_n = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  ccd_top #(.CW(4)) i_ccd_top (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .addr_i(addr_i),
    .wr_data_i(wr_data_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rd_data_o(rd_data_o),
    .align_req_i(align_req_i),
    .ch_out_o(ch_out_o),
    .ch_tick_o(ch_tick_o)
  );

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic step();
    @(posedge clk_sys_i);
    #1;
  endtask : step

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, then fall to zero
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk($sformatf("read %h", a), exp, rd_data_o);
    step();
    chk("read data idle", 8'h00, rd_data_o);
  endtask : rd_chk

  // one full high phase then one full low phase, in clk cycles
  task automatic measure(output int hi, output int lo);
    int n;
    n = 0;
    hi = 0;
    lo = 0;
    tick_n = 0;
    while (ch_out_o !== 1'b0 && n < 400) begin step(); n++; end
    while (ch_out_o !== 1'b1 && n < 400) begin step(); n++; end
    while (ch_out_o === 1'b1 && n < 400) begin
      if (ch_tick_o === 1'b1) tick_n++;
      step();
      n++;
      hi++;
    end
    while (ch_out_o === 1'b0 && n < 400) begin
      if (ch_tick_o === 1'b1) tick_n++;
      step();
      n++;
      lo++;
    end
    if (n >= 400) begin
      err_count++;
      $display("CHECK FAILED period wait expected edge seen none");
      conclude();
    end
  endtask : measure

  // hold an alignment request, then count cycles from release to first high output
  task automatic align_time(output int t);
    @(posedge clk_sys_i);
    align_req_i <= 1'b1;
    repeat (6) step();
    chk("output held during alignment", 8'h00, {7'h00, ch_out_o});
    rd_chk(`CCD_ADDR_STAT, 8'h1c);
    @(posedge clk_sys_i);
    align_req_i <= 1'b0;
    #1;
    t = 0;
    while (ch_out_o !== 1'b1 && t < 100) begin step(); t++; end
    if (t >= 100) begin
      err_count++;
      $display("CHECK FAILED restart wait expected high seen low");
      conclude();
    end
  endtask : align_time

  // ----------------------------------------------------------------
  // period table: counts, correction disable, control, high, low
  // ----------------------------------------------------------------
  logic [7:0] t_cnt [8] = '{8'h20, 8'h03, 8'h20, 8'h10, 8'h20, 8'h10, 8'h10, 8'h00};
  logic [7:0] t_dcc [8] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01};
  logic [7:0] t_ctl [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h10, 8'h30, 8'h04};
  int t_hi [8] = '{2, 8, 4, 4, 1, 1, 1, 2};
  int t_lo [8] = '{6, 2, 4, 2, 1, 2, 1, 2};

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  logic [8:0] addrs [5] = '{`CCD_ADDR_PHASE, `CCD_ADDR_LOHI, `CCD_ADDR_CTRL, `CCD_ADDR_DCC, 9'h1a4};
  logic [7:0] masks [5] = '{8'hff, 8'hff, `CCD_CTL_MASK, `CCD_DCC_MASK, 8'h00};

  initial begin
    int hi;
    int lo;
    int t0;
    int t1;
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;

    for (int i = 0; i < 5; i++) rd_chk(addrs[i], 8'h00);
    for (int i = 0; i < 5; i++) wr(addrs[i], 8'hff);
    for (int i = 0; i < 5; i++) rd_chk(addrs[i], masks[i]);
    for (int i = 0; i < 4; i++) wr(addrs[i], 8'h00);
    $display("test registers done");

    for (int i = 0; i < 8; i++) begin
      wr(`CCD_ADDR_LOHI, t_cnt[i]);
      wr(`CCD_ADDR_DCC, t_dcc[i]);
      wr(`CCD_ADDR_CTRL, t_ctl[i]);
      repeat (20) step();
      measure(hi, lo);
      chk($sformatf("high time row %0d", i), 8'(t_hi[i]), 8'(hi));
      chk($sformatf("low time row %0d", i), 8'(t_lo[i]), 8'(lo));
    end
    $display("test periods done");

    // forcing high with ignore-alignment set
    wr(`CCD_ADDR_CTRL, 8'h0c);
    repeat (2) step();
    for (int i = 0; i < 16; i++) begin
      chk("forced high", 8'h01, {7'h00, ch_out_o});
      step();
    end
    // ignore-alignment: a held request leaves the output running
    wr(`CCD_ADDR_CTRL, 8'h08);
    @(posedge clk_sys_i);
    align_req_i <= 1'b1;
    repeat (6) step();
    measure(hi, lo);
    chk("ignored request high", 8'h02, 8'(hi));
    chk("ignored request low", 8'h02, 8'(lo));
    chk("ticks per period", 8'h01, 8'(tick_n));
    @(posedge clk_sys_i);
    align_req_i <= 1'b0;
    $display("test force and ignore done");

    // restart timing after alignment: phase offset and start levels
    wr(`CCD_ADDR_CTRL, 8'h00);
    align_time(t0);
    wr(`CCD_ADDR_PHASE, 8'h03);
    align_time(t1);
    chk("phase offset delay", 8'h03, 8'(t1 - t0));
    wr(`CCD_ADDR_PHASE, 8'h00);
    wr(`CCD_ADDR_CTRL, 8'h02);
    align_time(t1);
    chk("stage two starts high", 8'h01, {7'h00, t1 < t0});
    wr(`CCD_ADDR_CTRL, 8'h01);
    align_time(t1);
    chk("stage one start level moves edge", 8'h01, {7'h00, t1 != t0});
    $display("test alignment done");

    conclude();
  end

endmodule : ccd_top_tb
